// [hdl/lrb_ram.sv]
// Purpose: large embedded dual-port ram block with apb setup
// Assumes: both ports and the bus run on pclk
// Notes:   read data is word-lane aligned, unused bits read zero
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
module lrb_ram (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          ce_a,
  input  wire logic                          clr_a,
  input  wire logic                          we_a,
  input  wire logic [lrb_pkg::ADDR_W-1:0]    addr_a,
  input  wire logic [lrb_pkg::BE_W-1:0]      be_a,
  input  wire logic [lrb_pkg::DBUS_W-1:0]    wdata_a,
  output logic      [lrb_pkg::DBUS_W-1:0]    rdata_a,
  input  wire logic                          ce_b,
  input  wire logic                          clr_b,
  input  wire logic                          we_b,
  input  wire logic [lrb_pkg::ADDR_W-1:0]    addr_b,
  input  wire logic [lrb_pkg::BE_W-1:0]      be_b,
  input  wire logic [lrb_pkg::DBUS_W-1:0]    wdata_b,
  output logic      [lrb_pkg::DBUS_W-1:0]    rdata_b
);
  import lrb_pkg::*;

  typedef struct packed {
    lrb_mode_t   mode;
    logic [2:0]  wa;
    logic [2:0]  wb;
    logic        oba;
    logic        obb;
    logic        nra;
    logic        nrb;
    logic        beu;
    logic [15:0] wcnt;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lrb_st_t;

  lrb_st_t st_ff;
  lrb_st_t nxt_st;

  logic                 we_aq;
  logic                 we_bq;
  logic [ADDR_W-1:0]    addr_aq;
  logic [ADDR_W-1:0]    addr_bq;
  logic [BE_W-1:0]      be_aq;
  logic [BE_W-1:0]      be_bq;
  logic [DBUS_W-1:0]    wd_aq;
  logic [DBUS_W-1:0]    wd_bq;
  logic [DBUS_W-1:0]    rword_a;
  logic [DBUS_W-1:0]    rword_b;
  logic                 legal;
  logic                 wide;
  logic                 wen_a;
  logic                 wen_b;
  logic                 rd_a;
  logic                 rd_b;
  logic                 rdq_a;
  logic [15:0]          be16_a;
  logic [15:0]          be16_b;
  logic [ROW_W-1:0]     d_a;
  logic [ROW_W-1:0]     d_b;
  logic [ROW_AW-1:0]    row_a;
  logic [ROW_AW-1:0]    row_b;
  logic [ROW_AW-1:0]    row_ra;
  logic [3:0]           base_a;
  logic [3:0]           base_b;
  logic [3:0]           base_ra;
  logic [3:0]           base_rb;
  logic [2:0]           rwd_a;
  logic [2:0]           rwd_b;
  logic                 nr_rb;
  logic [ROW_W-1:0]     rw_a;
  logic [ROW_W-1:0]     rw_b;
  logic [DBUS_W-1:0]    o9_a;
  logic [DBUS_W-1:0]    o9_b;
  logic [63:0]          o8_a;
  logic [63:0]          o8_b;
  logic                 setup;
  logic                 acc;
  logic                 hit_reg;
  logic [31:0]          rd_mux;

  // ==========================================================
  // address helpers
  // row of the 144-bit array; high address bits unused when wide
  function automatic logic [ROW_AW-1:0] row_of(input logic [2:0] w,
                                              input logic [15:0] a);
    logic [15:0] s;
    s = a >> (3'h4 - w);
    return s[ROW_AW-1:0];
  endfunction

  // first lane of the addressed word inside its row
  function automatic logic [3:0] base_of(input logic [2:0] w,
                                         input logic [15:0] a);
    logic [3:0] m;
    m = 4'hf >> w;
    return 4'((a[3:0] & m) << w);
  endfunction

  function automatic logic [4:0] lanes_of(input logic [2:0] w);
    return 5'(5'h01 << w);
  endfunction

  // ==========================================================
  // port front ends, both on the block clock
  lrb_port u_port_a (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce_a),
    .clr     (clr_a),
    .we      (we_a),
    .addr    (addr_a),
    .be      (be_a),
    .wdata   (wdata_a),
    .rd_word (rword_a),
    .rd_stb  (rdq_a),
    .obyp    (st_ff.oba),
    .we_q    (we_aq),
    .addr_q  (addr_aq),
    .be_q    (be_aq),
    .wd_q    (wd_aq),
    .rdata   (rdata_a)
  );

  lrb_port u_port_b (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce_b),
    .clr     (clr_b),
    .we      (we_b),
    .addr    (addr_b),
    .be      (be_b),
    .wdata   (wdata_b),
    .rd_word (rword_b),
    .rd_stb  (rd_b),
    .obyp    (st_ff.obb),
    .we_q    (we_bq),
    .addr_q  (addr_bq),
    .be_q    (be_bq),
    .wd_q    (wd_bq),
    .rdata   (rdata_b)
  );

  // ==========================================================
  // configuration legality and access decode
  always_comb begin
    wide = (st_ff.mode == MODE_SDP || st_ff.mode == MODE_FIFO) &&
           (st_ff.wa == W_X144);
    case (st_ff.mode)
      MODE_TDP: legal = (st_ff.wa <= W_X72) && (st_ff.wb <= W_X72);
      MODE_SP:  legal = (st_ff.wa <= W_X72);
      default:  legal = (st_ff.wa <= W_X144) && (st_ff.wb <= W_X144) &&
                        ((st_ff.wa == W_X144) == (st_ff.wb == W_X144));
    endcase
  end

  // port a writes in every mode; port b writes only in true dual
  assign wen_a = ce_a & we_aq & legal;
  assign wen_b = ce_b & we_bq & legal & (st_ff.mode == MODE_TDP);
  assign rd_a  = ~we_aq & legal &
                 (st_ff.mode == MODE_TDP || st_ff.mode == MODE_SP);
  assign rd_b  = ~we_bq & legal & (st_ff.mode != MODE_SP);
  assign rdq_a = wide ? rd_b : rd_a;

  // byte enables, all asserted unless software opts in
  always_comb begin
    be16_a = {8'h00, be_aq};
    if (wide) begin
      be16_a = {be_bq, be_aq};
    end
    if (!st_ff.beu || st_ff.wa == W_X9) begin
      be16_a = 16'hffff;
    end
    be16_b = (!st_ff.beu || st_ff.wb == W_X9) ? 16'hffff :
             {8'h00, be_bq};
  end

  // write data widened to a row; wide mode joins both buses
  always_comb begin
    d_a = {72'h0, wd_aq};
    if (wide) begin
      d_a = st_ff.nra ? {16'h0, wd_bq[63:0], wd_aq[63:0]} :
                        {wd_bq, wd_aq};
    end
    d_b = {72'h0, wd_bq};
  end

  assign row_a   = row_of(st_ff.wa, addr_aq);
  assign row_b   = row_of(st_ff.wb, addr_bq);
  assign base_a  = base_of(st_ff.wa, addr_aq);
  assign base_b  = base_of(st_ff.wb, addr_bq);
  assign row_ra  = wide ? row_b : row_a;
  assign base_ra = wide ? 4'h0 : base_a;
  assign base_rb = wide ? 4'h8 : base_b;
  assign rwd_a   = wide ? W_X72 : st_ff.wa;
  assign rwd_b   = wide ? W_X72 : st_ff.wb;
  assign nr_rb   = wide ? st_ff.nra : st_ff.nrb;

  // ==========================================================
  // storage: one array per nine-bit lane, never reset
  for (genvar p = 0; p < LANES; p++) begin : g_lane
    logic [LANE_W-1:0] mem_l [ROWS];
    logic [4:0]        off_a;
    logic [4:0]        off_b;
    logic              hit_a;
    logic              hit_b;
    logic              wr_a;
    logic              wr_b;
    logic [LANE_W-1:0] dl_a;
    logic [LANE_W-1:0] dl_b;

    assign off_a = 5'(p) - {1'b0, base_a};
    assign off_b = 5'(p) - {1'b0, base_b};
    assign hit_a = (5'(p) >= {1'b0, base_a}) &&
                   (off_a < lanes_of(st_ff.wa));
    assign hit_b = (5'(p) >= {1'b0, base_b}) &&
                   (off_b < lanes_of(st_ff.wb));
    // eight-bit lanes pack densely on the data bus
    assign dl_a = st_ff.nra ? {1'b0, d_a[8*off_a[3:0] +: 8]} :
                              d_a[9*off_a[3:0] +: 9];
    assign dl_b = st_ff.nrb ? {1'b0, d_b[8*off_b[3:0] +: 8]} :
                              d_b[9*off_b[3:0] +: 9];
    assign wr_a = wen_a & hit_a & be16_a[off_a[3:0]];
    assign wr_b = wen_b & hit_b & be16_b[off_b[3:0]];

    // lane write; port b wins a same-row collision
    always_ff @(posedge pclk) begin
      if (wr_a) begin
        mem_l[row_a] <= dl_a;
      end
      if (wr_b) begin
        mem_l[row_b] <= dl_b;
      end
    end

    assign rw_a[9*p +: 9] = mem_l[row_ra];
    assign rw_b[9*p +: 9] = mem_l[row_b];
  end

  // ==========================================================
  // read word extraction onto each 72-bit output bus
  for (genvar k = 0; k < BE_W; k++) begin : g_out
    logic [3:0] la;
    logic [3:0] lb;

    assign la = base_ra + 4'(k);
    assign lb = base_rb + 4'(k);
    assign o9_a[9*k +: 9] = (5'(k) < lanes_of(rwd_a)) ?
                            rw_a[9*la +: 9] : 9'h000;
    assign o9_b[9*k +: 9] = (5'(k) < lanes_of(rwd_b)) ?
                            rw_b[9*lb +: 9] : 9'h000;
    assign o8_a[8*k +: 8] = o9_a[9*k +: 8];
    assign o8_b[8*k +: 8] = o9_b[9*k +: 8];
  end

  assign rword_a = st_ff.nra ? {8'h00, o8_a} : o9_a;
  assign rword_b = nr_rb ? {8'h00, o8_b} : o9_b;

  // ==========================================================
  // apb slave, no wait states, registers and write counter
  assign setup   = psel & ~penable;
  assign acc     = psel & penable & st_ff.pready;
  assign hit_reg = (paddr == OFS_CTRL) || (paddr == OFS_STAT) ||
                   (paddr == OFS_WCNT);

  always_comb begin
    case (paddr)
      OFS_CTRL: rd_mux = {19'h0, st_ff.beu, st_ff.nrb, st_ff.nra,
                          st_ff.obb, st_ff.oba, st_ff.wb, st_ff.wa,
                          st_ff.mode};
      OFS_STAT: rd_mux = {28'h0, we_bq, we_aq, wide, ~legal};
      OFS_WCNT: rd_mux = {16'h0, st_ff.wcnt};
      default:  rd_mux = 32'h0;
    endcase
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.pready  = setup;
    nxt_st.pslverr = setup & ~hit_reg;
    if (setup) begin
      nxt_st.prdata = pwrite ? 32'h0 : rd_mux;
    end
    if (acc && pwrite && paddr == OFS_CTRL) begin
      nxt_st.mode = lrb_mode_t'(pwdata[CT_MODE +: 2]);
      nxt_st.wa   = pwdata[CT_WA +: 3];
      nxt_st.wb   = pwdata[CT_WB +: 3];
      nxt_st.oba  = pwdata[CT_OBA];
      nxt_st.obb  = pwdata[CT_OBB];
      nxt_st.nra  = pwdata[CT_NRA];
      nxt_st.nrb  = pwdata[CT_NRB];
      nxt_st.beu  = pwdata[CT_BEU];
    end
    if (wen_a || wen_b) begin
      nxt_st.wcnt = 16'(st_ff.wcnt + 16'h0001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= lrb_st_t'({CTRL_RST[12:0], 50'h0});
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata  = st_ff.prdata;
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;

  // ==========================================================
  // checks
  property p_no_tdp_wide;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.mode == MODE_TDP && st_ff.wa == W_X144) |-> !legal && !wen_a;
  endproperty
  a_no_tdp_wide: assert property (p_no_tdp_wide)
    else $error("144-bit width accepted in true dual-port");

  property p_wide_pair;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.mode == MODE_SDP && (st_ff.wa == W_X144) != (st_ff.wb == W_X144))
      |-> !legal;
  endproperty
  a_wide_pair: assert property (p_wide_pair)
    else $error("144-bit width paired with another width");

  property p_be_default;
    @(posedge pclk) disable iff (!presetn)
    !st_ff.beu |-> (be16_a == 16'hffff && be16_b == 16'hffff);
  endproperty
  a_be_default: assert property (p_be_default)
    else $error("byte enables not defaulted to asserted");

  property p_sel_excl;
    @(posedge pclk) disable iff (!presetn)
    we_aq |-> !rd_a && (!we_bq || !rd_b);
  endproperty
  a_sel_excl: assert property (p_sel_excl)
    else $error("read and write on one port together");

  property p_sp_idle_b;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.mode == MODE_SP) |-> (!rd_b && !wen_b);
  endproperty
  a_sp_idle_b: assert property (p_sp_idle_b)
    else $error("port b active in single-port mode");

  property p_wcnt;
    @(posedge pclk) disable iff (!presetn)
    (wen_a || wen_b) |=> st_ff.wcnt == 16'($past(st_ff.wcnt) + 16'h0001);
  endproperty
  a_wcnt: assert property (p_wcnt)
    else $error("write not counted");

endmodule

// [hdl/lrb_pkg.sv]
// Purpose: shared constants for the large dual-port ram block
// Assumes: single clock pclk, apb register access
// Notes:   port widths are coded as log2 of the lane count
package lrb_pkg;

  // ==========================================================
  // storage geometry
  localparam int ROWS       = 4096;
  localparam int LANES      = 16;
  localparam int LANE_W     = 9;
  localparam int ROW_W      = LANES * LANE_W;
  localparam int TOTAL_BITS = ROWS * ROW_W;
  localparam int ROW_AW     = 12;
  localparam int ADDR_W     = 16;
  localparam int BE_W       = 8;
  localparam int DBUS_W     = 72;

  // ==========================================================
  // port width codes (lanes = 1 << code)
  localparam logic [2:0] W_X9   = 3'h0;
  localparam logic [2:0] W_X18  = 3'h1;
  localparam logic [2:0] W_X36  = 3'h2;
  localparam logic [2:0] W_X72  = 3'h3;
  localparam logic [2:0] W_X144 = 3'h4;

  typedef enum logic [1:0] {
    MODE_TDP  = 2'b00,
    MODE_SDP  = 2'b01,
    MODE_SP   = 2'b10,
    MODE_FIFO = 2'b11
  } lrb_mode_t;

  // ==========================================================
  // apb register map
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_WCNT = 12'h008;
  localparam int CT_MODE = 0;
  localparam int CT_WA   = 2;
  localparam int CT_WB   = 5;
  localparam int CT_OBA  = 8;
  localparam int CT_OBB  = 9;
  localparam int CT_NRA  = 10;
  localparam int CT_NRB  = 11;
  localparam int CT_BEU  = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

endpackage

// [hdl/lrb_port.sv]
// Purpose: input capture and read output stage of one ram port
// Assumes: all inputs come from logic on pclk
// Notes:   clear is applied on the clock edge
`timescale 1ns/10ps
module lrb_port (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          ce,
  input  wire logic                          clr,
  input  wire logic                          we,
  input  wire logic [lrb_pkg::ADDR_W-1:0]    addr,
  input  wire logic [lrb_pkg::BE_W-1:0]      be,
  input  wire logic [lrb_pkg::DBUS_W-1:0]    wdata,
  input  wire logic [lrb_pkg::DBUS_W-1:0]    rd_word,
  input  wire logic                          rd_stb,
  input  wire logic                          obyp,
  output logic                               we_q,
  output logic      [lrb_pkg::ADDR_W-1:0]    addr_q,
  output logic      [lrb_pkg::BE_W-1:0]      be_q,
  output logic      [lrb_pkg::DBUS_W-1:0]    wd_q,
  output logic      [lrb_pkg::DBUS_W-1:0]    rdata
);
  import lrb_pkg::*;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0]   be;
    logic [DBUS_W-1:0] wd;
    logic [DBUS_W-1:0] rd;
    logic [DBUS_W-1:0] q;
  } lrb_pst_t;

  lrb_pst_t st_ff;
  lrb_pst_t nxt_st;

  // ==========================================================
  // capture and output pipeline
  always_comb begin
    nxt_st = st_ff;
    if (clr) begin
      nxt_st = '0;
    end else if (ce) begin
      nxt_st.we   = we;
      nxt_st.addr = addr;
      nxt_st.be   = be;
      nxt_st.wd   = wdata;
      if (rd_stb) begin
        nxt_st.rd = rd_word;
      end
      if (obyp) begin
        nxt_st.q = rd_stb ? rd_word : st_ff.q;
      end else begin
        nxt_st.q = st_ff.rd;
      end
    end
  end

  // state register, held when clock enable and clear are both low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign we_q   = st_ff.we;
  assign addr_q = st_ff.addr;
  assign be_q   = st_ff.be;
  assign wd_q   = st_ff.wd;
  assign rdata  = st_ff.q;

  // ==========================================================
  // checks
  property p_capture;
    @(posedge pclk) disable iff (!presetn)
    (ce && !clr) |=> (we_q == $past(we) && addr_q == $past(addr));
  endproperty
  a_capture: assert property (p_capture)
    else $error("port inputs not captured");

  property p_ce_hold;
    @(posedge pclk) disable iff (!presetn)
    (!ce && !clr) |=> ($stable(addr_q) && $stable(rdata));
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("port state moved with clock enable low");

  property p_clr;
    @(posedge pclk) disable iff (!presetn)
    clr |=> (addr_q == '0 && rdata == '0 && !we_q);
  endproperty
  a_clr: assert property (p_clr)
    else $error("port clear did not clear registers");

  property p_out_path;
    @(posedge pclk) disable iff (!presetn)
    (ce && !clr && rd_stb) ##1 (ce && !clr && !obyp && !$past(obyp))
      |=> (rdata == $past(rd_word, 2));
  endproperty
  a_out_path: assert property (p_out_path)
    else $error("registered read data late or wrong");

  property p_byp_path;
    @(posedge pclk) disable iff (!presetn)
    (ce && !clr && rd_stb && obyp) |=> (rdata == $past(rd_word));
  endproperty
  a_byp_path: assert property (p_byp_path)
    else $error("bypassed read data late or wrong");

endmodule

// [testbench/lrb_fab.sv]
// Purpose: fabric-side user logic driving one ram port
// Assumes: requests launched right after a rising pclk edge
// Notes:   idle data lines carry the inverse of the last word
`timescale 1ns/10ps
module lrb_fab (
  input  wire logic                       pclk,
  output logic                            ce,
  output logic                            clr,
  output logic                            we,
  output logic [lrb_pkg::ADDR_W-1:0]      addr,
  output logic [lrb_pkg::BE_W-1:0]        be,
  output logic [lrb_pkg::DBUS_W-1:0]      wdata,
  input  wire logic [lrb_pkg::DBUS_W-1:0] rdata
);
  import lrb_pkg::*;

  // ==========================================================
  // idle levels at time zero
  initial begin
    ce    = 1'b0; // port held until the first request
    clr   = 1'b0;
    we    = 1'b0;
    addr  = '0;
    be    = 8'hff;
    wdata = '0;
  end

  // one request per edge, all fields change together
  task automatic put(input logic c, w, input logic [ADDR_W-1:0] a,
                     input logic [BE_W-1:0] b, input logic [DBUS_W-1:0] d);
    @(posedge pclk);
    ce    <= c;
    clr   <= 1'b0;
    we    <= w;
    addr  <= a;
    be    <= b;
    wdata <= d;
  endtask

  // write, then fall back to a read so it is not repeated
  task automatic wr(input logic w, input logic [ADDR_W-1:0] a,
                    input logic [BE_W-1:0] b, input logic [DBUS_W-1:0] d);
    put(1'b1, w, a, b, d);
    put(1'b1, 1'b0, a, b, ~d);
  endtask

  // read, sampled after the stated number of edges
  task automatic rd(input logic [ADDR_W-1:0] a, input int lat,
                    output logic [DBUS_W-1:0] q);
    put(1'b1, 1'b0, a, be, wdata);
    repeat (lat) @(posedge pclk);
    #1 q = rdata;
  endtask

  // clear pulse lasting one edge
  task automatic clear();
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask
endmodule

// [testbench/large_dual_port_ram_block_tb.sv]
// Purpose: self-checking bench for the large dual-port ram block
// Assumes: both ports and the apb bus run on pclk
// Notes:   expected words come from lane merge functions
`timescale 1ns/10ps
module large_dual_port_ram_block_tb;
  import lrb_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  logic              ce_a, clr_a, we_a, ce_b, clr_b, we_b;
  logic [ADDR_W-1:0] addr_a, addr_b, a;
  logic [BE_W-1:0]   be_a, be_b, ba, bb;
  logic [DBUS_W-1:0] wdata_a, wdata_b, rdata_a, rdata_b;
  logic [DBUS_W-1:0] d0, d1, d2, d3, qa, qb;
  logic [9:0]        t;
  int                n_errors = 0;
  int                cmp_count = 0;

  lrb_ram dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_a(ce_a),
    .clr_a(clr_a), .we_a(we_a), .addr_a(addr_a), .be_a(be_a),
    .wdata_a(wdata_a), .rdata_a(rdata_a), .ce_b(ce_b), .clr_b(clr_b),
    .we_b(we_b), .addr_b(addr_b), .be_b(be_b), .wdata_b(wdata_b),
    .rdata_b(rdata_b));
  lrb_fab fab_a (.pclk(pclk), .ce(ce_a), .clr(clr_a), .we(we_a),
    .addr(addr_a), .be(be_a), .wdata(wdata_a), .rdata(rdata_a));
  lrb_fab fab_b (.pclk(pclk), .ce(ce_b), .clr(clr_b), .we(we_b),
    .addr(addr_b), .be(be_b), .wdata(wdata_b), .rdata(rdata_b));

  // ==========================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    summarize();
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [143:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // setup cycle, then access until pready is seen
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("apb_wait", 1'b0, 1'b1);
  endtask

  function automatic logic [31:0] cfg(logic [1:0] m, logic [2:0] wa, wb,
                                      logic bp, n8, bu);
    logic [31:0] c;
    c = '0;
    c[CT_MODE+:2] = m;
    c[CT_WA+:3] = wa;
    c[CT_WB+:3] = wb;
    c[CT_OBA] = bp;
    c[CT_OBB] = bp;
    c[CT_NRA] = n8;
    c[CT_NRB] = n8;
    c[CT_BEU] = bu;
    return c;
  endfunction

  // lanes of width lw taken from n where enabled
  function automatic logic [71:0] merge(logic [71:0] o, n,
                                        logic [7:0] b, int lw);
    logic [71:0] r;
    r = o;
    for (int i = 0; i < 8; i++)
      for (int j = 0; j < lw; j++)
        if (b[i]) r[lw*i+j] = n[lw*i+j];
    return r;
  endfunction

  function automatic logic [71:0] rnd();
    logic [95:0] r;
    r = {$urandom, $urandom, $urandom};
    return r[71:0];
  endfunction

  // ==========================================================
  // main sequence
  logic [9:0] tbl [7] = '{10'h01b, 10'h124, 10'h363, 10'h264, 10'h09b,
                          10'h0db, 10'h058};
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    void'($urandom(93674));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, '0, q, e);
    chk("ctrl_rst", q, CTRL_RST);
    apb(1'b0, 12'h00c, '0, q, e);
    chk("bad_addr", {q, e}, 33'h1);
    apb(1'b1, OFS_STAT, 32'hffff_ffff, q, e);
    chk("ro_write", e, 1'b0);
    chk("rdata_rst", {rdata_b, rdata_a}, '0);
    $display("test reset done");
    foreach (tbl[i]) begin
      t = tbl[i];
      apb(1'b1, OFS_CTRL, cfg(t[7:6], t[5:3], t[2:0], 1'b0, 1'b0, 1'b1),
          q, e);
      apb(1'b0, OFS_STAT, '0, q, e);
      chk("legal", q[1:0], t[9:8]);
    end
    $display("test modes done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_CTRL, cfg(MODE_TDP, W_X72, W_X72, i[0], i[1], 1'b1),
          q, e);
      a = {3'h0, 13'($urandom)};
      if (i == 7) a = 16'h1fff;
      d0 = rnd();
      d1 = rnd();
      bb = 8'($urandom);
      fab_a.wr(1'b1, a, 8'hff, d0);
      fab_b.wr(1'b1, a, bb, d1);
      fab_a.rd(a, i[0] ? 2 : 3, qa);
      chk("lanes", qa, merge(merge('0, d0, 8'hff, i[1] ? 8 : 9), d1, bb,
          i[1] ? 8 : 9));
    end
    $display("test lanes done");
    apb(1'b1, OFS_CTRL, cfg(MODE_TDP, W_X72, W_X9, 1'b1, 1'b0, 1'b0), q, e);
    a = {3'h0, 13'($urandom)};
    d0 = rnd();
    fab_a.wr(1'b1, a, 8'h00, d0);
    for (int k = 0; k < 8; k++) begin
      fab_b.rd({a[12:0], 3'(k)}, 2, qb);
      chk("mixed", qb, {63'h0, d0[9*k+:9]});
    end
    $display("test mixed done");
    apb(1'b1, OFS_CTRL, cfg(MODE_SDP, W_X144, W_X144, 1'b0, 1'b0, 1'b1),
        q, e);
    a = {4'h0, 12'($urandom)};
    d0 = rnd();
    d1 = rnd();
    d2 = rnd();
    d3 = rnd();
    ba = 8'($urandom);
    bb = 8'($urandom);
    fork
      fab_a.wr(1'b1, a, 8'hff, d0);
      fab_b.wr(1'b0, a, 8'hff, d1);
    join
    fork
      fab_a.wr(1'b1, a, ba, d2);
      fab_b.wr(1'b0, a, bb, d3);
    join
    fork
      fab_a.rd(a, 3, qa);
      fab_b.rd(a, 3, qb);
    join
    chk("wide", {qb, qa},
        {merge(d1, d3, bb, 9), merge(d0, d2, ba, 9)});
    $display("test wide done");
    apb(1'b1, OFS_CTRL, cfg(MODE_TDP, W_X72, W_X72, 1'b1, 1'b0, 1'b1), q, e);
    a = {3'h0, 13'($urandom)};
    d0 = rnd();
    apb(1'b0, OFS_WCNT, '0, q, e);
    d1 = {40'h0, q};
    fab_a.wr(1'b1, a, 8'hff, d0);
    fab_a.put(1'b0, 1'b1, a, 8'hff, rnd());
    repeat (2) @(posedge pclk);
    // one write cycle only; the held write with ce low is not counted
    apb(1'b0, OFS_WCNT, '0, q, e);
    chk("wcnt", q, {16'h0, 16'(d1[15:0] + 16'h0001)});
    fab_a.rd(a, 2, qa);
    chk("ce_hold", qa, d0);
    fab_a.clear();
    #1 chk("clear", rdata_a, '0);
    $display("test ce_clr done");
    summarize();
  end
endmodule
